// file: hw/hot_pkg.sv
// Shared constants and types of the overhead packet transmitter
package hot_pkg;
    // ---------------------------------------------------------------
    // Queue geometry
    // ---------------------------------------------------------------
    localparam int AW = 8;
    localparam int LW = 9;
    localparam int DW = 9;
    localparam logic [LW-1:0] DEPTH = 9'h100;
    localparam int END_BIT = 8;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;

    // ---------------------------------------------------------------
    // Control and status fields
    // ---------------------------------------------------------------
    localparam int CTRL_W = 6;
    localparam int CTRL_START = 0;
    localparam int CTRL_FCS = 1;
    localparam int CTRL_FCSERR = 2;
    localparam int CTRL_ONES = 3;
    localparam int CTRL_REORD = 4;
    localparam int CTRL_INV = 5;
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [LW-1:0] THRESH_RST = 9'h010;
    localparam int ST_EMPTY = 0;
    localparam int ST_FULL = 1;
    localparam int ST_SPACE = 2;
    localparam int ST_OVF = 3;
    localparam int ST_UDF = 4;

    // ---------------------------------------------------------------
    // Line patterns and counts
    // ---------------------------------------------------------------
    localparam logic [7:0] FLAG = 8'h7E;
    localparam logic [7:0] ABORT_SEQ = 8'hFF;
    localparam logic [7:0] ONE_BIT = 8'h01;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [LW-1:0] MIN_QUEUED = 9'h002;
    localparam logic [1:0] MIN_FLAGS = 2'h2;
    localparam logic [4:0] MIN_ONES = 5'h0F;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] UNIT_BIT = 4'h1;

    typedef enum logic [2:0] {
        S_FILL, S_OPEN, S_DATA, S_FCS, S_CLOSE, S_ABORT
    } hot_state_e;
endpackage

// file: hw/hot_ram.sv
// Dual-port byte store with packet-end tag for the transmit queue
`timescale 1ns/1ns
module hot_ram (
    input wire logic clk_i,
    input wire logic wr_en_i,
    input wire logic [hot_pkg::AW-1:0] wr_addr_i,
    input wire logic [hot_pkg::DW-1:0] wr_data_i,
    input wire logic [hot_pkg::AW-1:0] rd_addr_i,
    output logic [hot_pkg::DW-1:0] rd_data_o
);
    // ---------------------------------------------------------------
    // Storage, independent write and read ports
    // ---------------------------------------------------------------
    logic [hot_pkg::DW-1:0] mem_q [0:(1<<hot_pkg::AW)-1];

    // Register side write port
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Line side read port, registered
    always_ff @(posedge clk_i) begin
        rd_data_o <= mem_q[rd_addr_i];
    end
endmodule

// file: hw/hot_top.sv
// Overhead packet transmitter: queue, framing, FCS, stuffing, fill
//
// Contract
// - Queue holds 256 tagged bytes with pointers and a fill level.
// - Status shows empty, full, and free space at or above threshold.
// - Write into a full queue is dropped and flags overflow.
// - Fetch from an empty queue flags underflow.
// - After a packet-end byte, pad when under two queued or start off.
// - Fetch from an empty queue turns into an abort.
// - Fill continues until two bytes queued and start enabled.
// - Reorder off sends bit 0 first; on sends bit 7 first.
// - With FCS on, append inverted CRC-16 x16+x12+x5+1.
// - FCS error insertion appends the CRC without inversion.
// - With FCS off, no check sequence is appended.
// - Inside a packet, a zero follows every five ones.
// - Flag fill sends at least two flags until packet start.
// - Ones fill: end flag, at least 15 ones, then start flag.
// - Back-to-back packets are separated by exactly two flags.
// - Abort sends FFh then fill until next packet start.
// - Inversion complements every line bit last.
// - Bytes go out first-sent bit from register position 0 unless reorder is on.
// - Storage reachable from either side independently.
// - Software selects fill type, reordering and inversion.
// - Flag pattern is 01111110.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module hot_top (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic slot_stb_i,
    output logic line_bit_o,
    output logic abort_o
);
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Mirror a byte
    function automatic logic [7:0] rev8(input logic [7:0] d);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
        end
        return r;
    endfunction

    // One bit of the reflected CRC-16
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b);
        logic [15:0] s;
        s = c >> 1;
        if (c[0] ^ b) begin
            s = s ^ hot_pkg::CRC_POLY;
        end
        return s;
    endfunction

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [hot_pkg::CTRL_W-1:0] ctrl_q;
    logic [hot_pkg::LW-1:0] thresh_q;
    logic [hot_pkg::LW-1:0] level_q;
    logic [hot_pkg::AW-1:0] wr_ptr_q;
    logic [hot_pkg::AW-1:0] rd_ptr_q;
    logic wr_d1_q;
    logic ovf_q;
    logic udf_q;
    logic [hot_pkg::DW-1:0] head;
    hot_pkg::hot_state_e state_q;
    hot_pkg::hot_state_e nxt_state;
    logic [7:0] sr_q;
    logic [7:0] nxt_sr;
    logic [3:0] bcnt_q;
    logic [3:0] nxt_len;
    logic [2:0] ones_q;
    logic [4:0] run_q;
    logic [1:0] fflag_q;
    logic end_q;
    logic nxt_end;
    logic fcs_hi_q;
    logic [15:0] crc_q;
    logic [15:0] crc_nxt;
    logic [15:0] fcs_val;
    logic full;
    logic push;
    logic pop;
    logic fetch_empty;
    logic [hot_pkg::LW-1:0] avail;
    logic [hot_pkg::LW-1:0] space;
    logic ready;
    logic fill_ok;
    logic stuff_now;
    logic stuff_act;
    logic done;
    logic cur_bit;
    logic [31:0] status;

    // ---------------------------------------------------------------
    // Queue bookkeeping
    // ---------------------------------------------------------------
    assign full = (level_q == hot_pkg::DEPTH);
    assign push = reg_wr_i && (reg_addr_i == hot_pkg::ADDR_TXDATA)
                  && !full;
    assign avail = level_q - {{(hot_pkg::LW-1){1'b0}}, wr_d1_q};
    assign space = hot_pkg::DEPTH - level_q;
    assign ready = (avail >= hot_pkg::MIN_QUEUED)
                   && ctrl_q[hot_pkg::CTRL_START];

    // Storage with separate write and read ports
    hot_ram u_ram (
        .clk_i(clk_i),
        .wr_en_i(push),
        .wr_addr_i(wr_ptr_q),
        .wr_data_i(reg_wdata_i[hot_pkg::DW-1:0]),
        .rd_addr_i(rd_ptr_q),
        .rd_data_o(head)
    );

    // Pointers and fill level
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            level_q <= '0;
            wr_d1_q <= 1'b0;
        end else begin
            wr_d1_q <= push;
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 8'h01;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 8'h01;
            end
            case ({push, pop})
                2'b10: level_q <= level_q + 9'h001;
                2'b01: level_q <= level_q - 9'h001;
                default: level_q <= level_q;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    // Control and threshold
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_q <= hot_pkg::CTRL_RST;
            thresh_q <= hot_pkg::THRESH_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == hot_pkg::ADDR_CTRL) begin
                ctrl_q <= reg_wdata_i[hot_pkg::CTRL_W-1:0];
            end
            if (reg_addr_i == hot_pkg::ADDR_THRESH) begin
                thresh_q <= reg_wdata_i[hot_pkg::LW-1:0];
            end
        end
    end

    // Sticky events, set wins over write-one clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ovf_q <= 1'b0;
            udf_q <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == hot_pkg::ADDR_STATUS) begin
                if (reg_wdata_i[hot_pkg::ST_OVF]) begin
                    ovf_q <= 1'b0;
                end
                if (reg_wdata_i[hot_pkg::ST_UDF]) begin
                    udf_q <= 1'b0;
                end
            end
            if (reg_wr_i && reg_addr_i == hot_pkg::ADDR_TXDATA && full) begin
                ovf_q <= 1'b1;
            end
            if (done && fetch_empty) begin
                udf_q <= 1'b1;
            end
        end
    end

    // Status word
    always_comb begin
        status = '0;
        status[hot_pkg::ST_EMPTY] = (level_q == '0);
        status[hot_pkg::ST_FULL] = full;
        status[hot_pkg::ST_SPACE] = (space >= thresh_q);
        status[hot_pkg::ST_OVF] = ovf_q;
        status[hot_pkg::ST_UDF] = udf_q;
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (srst_i || !reg_rd_i) begin
            reg_rdata_o <= '0;
        end else begin
            case (reg_addr_i)
                hot_pkg::ADDR_CTRL:
                    reg_rdata_o <= {26'h0, ctrl_q};
                hot_pkg::ADDR_THRESH:
                    reg_rdata_o <= {23'h0, thresh_q};
                hot_pkg::ADDR_STATUS:
                    reg_rdata_o <= status;
                hot_pkg::ADDR_LEVEL:
                    reg_rdata_o <= {23'h0, level_q};
                default:
                    reg_rdata_o <= '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Bit engine
    // ---------------------------------------------------------------
    assign stuff_now = (ones_q == hot_pkg::STUFF_RUN);
    assign stuff_act = (state_q == hot_pkg::S_DATA)
                       || (state_q == hot_pkg::S_FCS);
    assign cur_bit = stuff_now ? 1'b0 : sr_q[0];
    assign done = slot_stb_i && !stuff_now
                  && (bcnt_q == hot_pkg::UNIT_BIT);
    assign crc_nxt = crc_step(crc_q, sr_q[0]);
    assign fill_ok = ctrl_q[hot_pkg::CTRL_ONES]
                     ? (run_q >= hot_pkg::MIN_ONES)
                     : (fflag_q >= hot_pkg::MIN_FLAGS);
    assign fcs_val = ctrl_q[hot_pkg::CTRL_FCSERR]
                     ? ((state_q == hot_pkg::S_DATA) ? crc_nxt : crc_q)
                     : ~((state_q == hot_pkg::S_DATA) ? crc_nxt : crc_q);

    // Next unit when the current one finishes
    always_comb begin
        nxt_state = state_q;
        nxt_sr = hot_pkg::FLAG;
        nxt_len = hot_pkg::BYTE_BITS;
        nxt_end = end_q;
        pop = 1'b0;
        fetch_empty = 1'b0;
        case (state_q)
            hot_pkg::S_OPEN, hot_pkg::S_DATA: begin
                if (state_q == hot_pkg::S_DATA && end_q) begin
                    nxt_end = 1'b0;
                    if (ctrl_q[hot_pkg::CTRL_FCS]) begin
                        nxt_state = hot_pkg::S_FCS;
                        nxt_sr = fcs_val[7:0];
                    end else begin
                        nxt_state = hot_pkg::S_CLOSE;
                    end
                end else if (avail == '0) begin
                    fetch_empty = 1'b1;
                    nxt_state = hot_pkg::S_ABORT;
                    nxt_sr = hot_pkg::ABORT_SEQ;
                end else begin
                    pop = done;
                    nxt_state = hot_pkg::S_DATA;
                    nxt_end = head[hot_pkg::END_BIT];
                    nxt_sr = ctrl_q[hot_pkg::CTRL_REORD]
                             ? rev8(head[7:0]) : head[7:0];
                end
            end
            hot_pkg::S_FCS: begin
                if (!fcs_hi_q) begin
                    nxt_sr = fcs_val[15:8];
                end else begin
                    nxt_state = hot_pkg::S_CLOSE;
                end
            end
            hot_pkg::S_CLOSE, hot_pkg::S_ABORT, hot_pkg::S_FILL: begin
                if (ready && (state_q == hot_pkg::S_CLOSE
                              || (state_q == hot_pkg::S_FILL
                                  && fill_ok))) begin
                    nxt_state = hot_pkg::S_OPEN;
                end else begin
                    nxt_state = hot_pkg::S_FILL;
                    if (ctrl_q[hot_pkg::CTRL_ONES]) begin
                        nxt_sr = hot_pkg::ONE_BIT;
                        nxt_len = hot_pkg::UNIT_BIT;
                    end
                end
            end
            default: begin
                nxt_state = hot_pkg::S_FILL;
            end
        endcase
    end

    // Shift register, unit state and stuffing run
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= hot_pkg::S_FILL;
            sr_q <= hot_pkg::FLAG;
            bcnt_q <= hot_pkg::BYTE_BITS;
            ones_q <= '0;
            end_q <= 1'b0;
            fcs_hi_q <= 1'b0;
        end else if (slot_stb_i) begin
            if (stuff_now) begin
                ones_q <= '0;
            end else begin
                if (stuff_act) begin
                    ones_q <= sr_q[0] ? ones_q + 3'h1 : '0;
                end
                if (done) begin
                    state_q <= nxt_state;
                    sr_q <= nxt_sr;
                    bcnt_q <= nxt_len;
                    end_q <= nxt_end;
                    fcs_hi_q <= (state_q == hot_pkg::S_FCS);
                    if (nxt_state == hot_pkg::S_OPEN) begin
                        ones_q <= '0;
                    end
                end else begin
                    sr_q <= sr_q >> 1;
                    bcnt_q <= bcnt_q - 4'h1;
                end
            end
        end
    end

    // Frame check sequence over packet bits
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            crc_q <= hot_pkg::CRC_INIT;
        end else if (slot_stb_i && !stuff_now) begin
            if (state_q == hot_pkg::S_OPEN) begin
                crc_q <= hot_pkg::CRC_INIT;
            end else if (state_q == hot_pkg::S_DATA) begin
                crc_q <= crc_nxt;
            end
        end
    end

    // Fill length counters, cleared at the end of each unit outside fill
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_q <= '0;
            fflag_q <= '0;
        end else if (done) begin
            if (state_q != hot_pkg::S_FILL) begin
                run_q <= '0;
                fflag_q <= '0;
            end else begin
                if (ctrl_q[hot_pkg::CTRL_ONES] && run_q != 5'h1F) begin
                    run_q <= run_q + 5'h01;
                end
                if (!ctrl_q[hot_pkg::CTRL_ONES] && fflag_q != 2'h3) begin
                    fflag_q <= fflag_q + 2'h1;
                end
            end
        end
    end

    // Line outputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            line_bit_o <= 1'b1;
            abort_o <= 1'b0;
        end else begin
            abort_o <= done && fetch_empty;
            if (slot_stb_i) begin
                line_bit_o <= cur_bit ^ ctrl_q[hot_pkg::CTRL_INV];
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    a_level_ptrs:
        assert property (level_q[7:0] == wr_ptr_q - rd_ptr_q
                         && level_q <= hot_pkg::DEPTH)
        else $error("fill level disagrees with pointers");
    a_overflow_drop:
        assert property (reg_wr_i && reg_addr_i == hot_pkg::ADDR_TXDATA
                         && full |=> ovf_q && $stable(wr_ptr_q))
        else $error("write into full queue not dropped");
    a_underflow_abort:
        assert property (done && fetch_empty |=> udf_q && abort_o
                         && state_q == hot_pkg::S_ABORT)
        else $error("empty fetch did not abort");
    a_stuff_zero:
        assert property (slot_stb_i && stuff_now |=> line_bit_o
                         == $past(ctrl_q[hot_pkg::CTRL_INV]))
        else $error("stuffed zero missing");
    a_open_gate:
        assert property (state_q == hot_pkg::S_FILL
                         ##1 state_q == hot_pkg::S_OPEN
                         |-> $past(ready && fill_ok))
        else $error("packet opened while not ready");
    a_ones_run:
        assert property (state_q == hot_pkg::S_FILL
                         && ctrl_q[hot_pkg::CTRL_ONES] && done
                         && nxt_state == hot_pkg::S_OPEN
                         |-> run_q >= hot_pkg::MIN_ONES)
        else $error("ones fill too short");
    a_back_to_back:
        assert property (state_q == hot_pkg::S_CLOSE && done && ready
                         |=> state_q == hot_pkg::S_OPEN)
        else $error("extra fill between packets");
    a_fcs_select:
        assert property (state_q == hot_pkg::S_DATA && done && end_q
                         |=> state_q == ($past(ctrl_q[hot_pkg::CTRL_FCS])
                             ? hot_pkg::S_FCS : hot_pkg::S_CLOSE))
        else $error("wrong unit after packet end");
    a_abort_fill:
        assert property (state_q == hot_pkg::S_ABORT && done
                         |=> state_q == hot_pkg::S_FILL)
        else $error("abort not followed by fill");
    a_bit_hold:
        assert property (!slot_stb_i |=> $stable(line_bit_o))
        else $error("line bit moved without strobe");

    c_fcs_packet:
        cover property (state_q == hot_pkg::S_FCS && done && fcs_hi_q);
    c_abort:
        cover property (done && fetch_empty);
    c_ones_open:
        cover property (state_q == hot_pkg::S_FILL
                        && run_q >= hot_pkg::MIN_ONES
                        ##1 state_q == hot_pkg::S_OPEN);
endmodule

// file: dv/hot_framer_model.sv
// Framer-side bit slot strobe source and line bit collector
`timescale 1ns/1ns
module hot_framer_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic slow_i,
    input wire logic line_bit_i,
    output logic slot_stb_o
);
    logic [1:0] div_q = 2'h0;
    logic stb_q = 1'b0;
    bit rx[$];

    // One strobe per slot, every cycle or every third; bit taken after
    always @(posedge clk_i) begin
        div_q <= (srst_i || div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
        slot_stb_o <= !srst_i && (!slow_i || div_q == 2'h0);
        stb_q <= slot_stb_o;
        if (stb_q) rx.push_back(line_bit_i);
    end
endmodule

// file: dv/hot_top_tb.sv
// Self-checking bench for the overhead packet transmitter
`timescale 1ns/1ns
module hot_top_tb;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic slow = 1'b0;
    logic slot_stb_i;
    logic [31:0] reg_rdata_o;
    logic line_bit_o;
    logic abort_o;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    int aborts = 0;
    int mx;
    int nf;

    always #4 clk_i = ~clk_i;

    hot_top i_hot_top (.clk_i(clk_i), .srst_i(srst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .slot_stb_i(slot_stb_i),
        .line_bit_o(line_bit_o), .abort_o(abort_o));
    hot_framer_model i_hot_framer_model (.clk_i(clk_i), .srst_i(srst_i),
        .slow_i(slow), .line_bit_i(line_bit_o), .slot_stb_o(slot_stb_i));

    // Hang ceiling and abort pulse tally
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (abort_o === 1'b1) aborts <= aborts + 1;
        if (cycles == 20000) begin
            bad_count++;
            test_done();
        end
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] x,
                       input string m);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] x,
                      input string m);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, x, m);
    endtask

    // Destuffed bits of the first frame; nf counts flags after it
    function automatic void decode(input bit inv, output bit f[$]);
        bit d[$];
        bit b;
        bit seen;
        bit done;
        logic [7:0] w;
        int ones;
        w = 8'h00;
        ones = 0;
        seen = 0;
        done = 0;
        mx = 0;
        nf = 0;
        f = {};
        foreach (i_hot_framer_model.rx[k]) begin
            b = i_hot_framer_model.rx[k] ^ inv;
            w = {w[6:0], b};
            if (ones == 5 && !b) ones = 0;
            else begin
                d.push_back(b);
                ones = b ? ones + 1 : 0;
            end
            if (ones > mx) mx = ones;
            if (ones > 6) seen = 0;
            if (w == 8'h7E) begin
                if (seen && d.size() > 8) begin
                    if (f.size() == 0) f = d[0:d.size()-9];
                    else done = 1;
                end else if (f.size() != 0 && !done) nf++;
                seen = 1;
                d = {};
                ones = 0;
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic regs_test();
        rc(hot_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
        rc(hot_pkg::ADDR_THRESH, 32'h10, "thresh reset");
        rc(hot_pkg::ADDR_STATUS, 32'h05, "status reset");
        rc(hot_pkg::ADDR_LEVEL, 32'h0, "level reset");
        rc(8'h14, 32'h0, "unmapped");
        wr(hot_pkg::ADDR_THRESH, 32'h100);
        rc(hot_pkg::ADDR_STATUS, 32'h05, "space at 256");
        wr(hot_pkg::ADDR_THRESH, 32'h101);
        rc(hot_pkg::ADDR_STATUS, 32'h01, "no space");
        wr(hot_pkg::ADDR_THRESH, 32'h10);
        $display("register test done");
    endtask

    // Two like packets queued back to back, decoded off the line
    task automatic pkt(input logic [5:0] c, input bit s);
        bit e[$];
        bit f[$];
        logic [15:0] crc;
        logic [7:0] v;
        crc = 16'hFFFF;
        slow <= s;
        wr(hot_pkg::ADDR_CTRL, 32'h0);
        for (int r = 0; r < 4; r++) begin
            v = r[0] ? 8'hFC : 8'h3F;
            wr(hot_pkg::ADDR_TXDATA, {23'h0, r[0], v});
            for (int j = 0; j < 8 && r < 2; j++) begin
                e.push_back(v[c[hot_pkg::CTRL_REORD] ? 7 - j : j]);
                crc = (crc >> 1) ^ ((crc[0] ^ e[$]) ? 16'h8408 : 16'h0);
            end
        end
        for (int j = 0; j < 16 && c[hot_pkg::CTRL_FCS]; j++) begin
            e.push_back(c[hot_pkg::CTRL_FCSERR] ? crc[j] : ~crc[j]);
        end
        i_hot_framer_model.rx.delete();
        wr(hot_pkg::ADDR_CTRL, {26'h0, c} | 32'h1);
        repeat (900) @(posedge clk_i);
        decode(c[hot_pkg::CTRL_INV], f);
        chk(32'(f.size()), 32'(e.size()), "frame length");
        foreach (e[k]) begin
            if (k < f.size()) chk(32'(f[k]), 32'(e[k]), "frame bit");
        end
        chk(32'(nf), 32'h1, "flags between");
        if (c[hot_pkg::CTRL_ONES]) chk(32'(mx > 14), 32'h1, "ones");
        $display("packet test %h done", c);
    endtask

    // Overfill, then drain a packet with no end tag into an abort
    task automatic ovf_udf_test();
        logic [15:0] w;
        bit hit;
        w = 16'h0;
        hit = 0;
        slow <= 1'b0;
        wr(hot_pkg::ADDR_CTRL, 32'h0);
        wr(hot_pkg::ADDR_STATUS, 32'h18);
        for (int i = 0; i < 257; i++) wr(hot_pkg::ADDR_TXDATA, 32'h0);
        rc(hot_pkg::ADDR_LEVEL, 32'h100, "level full");
        rc(hot_pkg::ADDR_STATUS, 32'h0A, "full overflow");
        wr(hot_pkg::ADDR_STATUS, 32'h08);
        rc(hot_pkg::ADDR_STATUS, 32'h02, "overflow clear");
        aborts = 0;
        i_hot_framer_model.rx.delete();
        wr(hot_pkg::ADDR_CTRL, 32'h1);
        repeat (2400) @(posedge clk_i);
        chk(32'(aborts), 32'h1, "abort pulse");
        rc(hot_pkg::ADDR_STATUS, 32'h15, "underflow");
        foreach (i_hot_framer_model.rx[k]) begin
            w = {w[14:0], i_hot_framer_model.rx[k]};
            if (w == 16'hFF7E) hit = 1;
        end
        chk(32'(hit), 32'h1, "abort then flag");
        $display("overflow underflow test done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk_i);
        srst_i <= 1'b0;
        regs_test();
        pkt(6'h02, 1'b0);
        pkt(6'h06, 1'b0);
        pkt(6'h00, 1'b1);
        pkt(6'h30, 1'b1);
        pkt(6'h0A, 1'b0);
        ovf_udf_test();
        test_done();
    end
endmodule
